/* File: shared/scat_pkg.sv */
// Summary of operation
// - Indicator clear reaches User IO within 25 us
// - IO config writes applied within 30 us idle
// - IO config apply may wait for measurement end
// - Checksum of every register access kept readable
// - CRC-16 poly 0x8005, preset 0x0000, MISO data
// - Only complete MISO words, identity word first
// - Checksum read if gap 3..19 us, 8 us busy
// - Running: continuous and triggered, or indicator pending
// - Identity word is first MISO word, except in a checksum read
package scat_pkg;

    localparam int CLK_MHZ = 40;

    // Gap window bounds and User IO deadlines in microseconds
    localparam int WIN_MIN_IDLE_US = 3;
    localparam int WIN_MIN_BUSY_US = 8;
    localparam int WIN_MAX_US = 19;
    localparam int IO_CLEAR_MAX_US = 25;
    localparam int IO_FUNC_MAX_US = 30;

    localparam int GAP_W = 11;
    localparam logic [GAP_W-1:0] WIN_MIN_IDLE_CYC = GAP_W'(WIN_MIN_IDLE_US * CLK_MHZ);
    localparam logic [GAP_W-1:0] WIN_MIN_BUSY_CYC = GAP_W'(WIN_MIN_BUSY_US * CLK_MHZ);
    localparam logic [GAP_W-1:0] WIN_MAX_CYC = GAP_W'(WIN_MAX_US * CLK_MHZ);

    localparam logic [3:0] ACS_WRITE_READ = 4'hf;
    localparam logic [11:0] IO_PIN_TYPE_ADDR = 12'h002;
    localparam logic [7:0] CTRL_WORD_OFS = 8'h00;
    localparam logic [7:0] IND_CTRL_OFS = 8'h12;
    localparam int SAMPLE_FLAG_BIT = 15;

    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;

    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } scat_reg_req_t;

    typedef struct packed {
        logic miso;
        logic miso_oe_n;
    } scat_miso_pin_t;

endpackage

/* File: design/scat_crc16.sv */
`timescale 1ns/1ps
module scat_crc16 (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic feed,
    input wire logic [15:0] word,
    output logic [15:0] crc
);
    logic [15:0] crc_reg;
    logic [15:0] crc_next;

    // Bitwise, MSB first, no reflection, no final xor
    function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = (r[15] ^ w[i]) ? ({r[14:0], 1'b0} ^ scat_pkg::CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    assign crc_next = crc_word(crc_reg, word);

    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            crc_reg <= scat_pkg::CRC_INIT;
        end else if (feed) begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;
endmodule // scat_crc16

/* File: design/scat_spi_slave.sv */
`timescale 1ns/1ps
module scat_spi_slave #(
    parameter int N_SENSORS = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic nss_n,
    input wire logic [15:0] system_identity_word,
    input wire logic [N_SENSORS-1:0] sensor_go,
    input wire logic [N_SENSORS-1:0] continuous_measure_bit,
    input wire logic [N_SENSORS-1:0] sample_indicator_flag,
    input wire logic [15:0] reg_rdata,
    output scat_pkg::scat_reg_req_t reg_req,
    output scat_pkg::scat_miso_pin_t miso_pin,
    output logic indicator_clear_pulse,
    output logic io_apply_pulse,
    output logic measure_running,
    output logic checksum_active
);
    // Pin synchronisers; stage 0 feeds stage 1 only
    logic [2:0] sck_sync_reg;
    logic [2:0] nss_sync_reg;
    logic [1:0] mosi_sync_reg;

    logic [3:0] bit_cnt_reg;
    logic [4:0] word_cnt_reg;
    logic [15:0] rx_reg;
    logic [11:0] addr_reg;
    logic write_reg;
    logic [3:0] pos_reg;
    logic chk_txn_reg;
    logic pend_chk_reg;
    logic [scat_pkg::GAP_W-1:0] gap_reg;
    logic [15:0] ident_word_reg;
    logic [15:0] data_word_reg;
    logic rd_dly_reg;
    logic clr_seen_reg;
    logic io_seen_reg;
    logic io_wait_reg;
    logic clr_pulse_reg;
    logic io_pulse_reg;
    logic running_reg;
    logic miso_reg;
    logic miso_oe_n_reg;
    scat_pkg::scat_reg_req_t req_reg;

    wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
    wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
    wire selected = ~nss_sync_reg[1];
    wire nss_fall = ~nss_sync_reg[1] & nss_sync_reg[2];
    wire nss_rise = nss_sync_reg[1] & ~nss_sync_reg[2];
    wire [15:0] rx_next = {rx_reg[14:0], mosi_sync_reg[1]};
    wire word_done = sck_rise & selected & (bit_cnt_reg == 4'hf);
    wire reg_word_done = word_done & ~chk_txn_reg;
    wire first_word = (word_cnt_reg == 5'h00);
    wire [11:0] addr_inc = addr_reg + 12'h001;

    wire running_next = |(continuous_measure_bit & sensor_go) | |(sensor_go & ~sample_indicator_flag);

    // Checksum read decision at the select falling edge
    wire [scat_pkg::GAP_W-1:0] win_min = running_reg ? scat_pkg::WIN_MIN_BUSY_CYC : scat_pkg::WIN_MIN_IDLE_CYC;
    wire gap_in_window = (gap_reg >= win_min) && (gap_reg <= scat_pkg::WIN_MAX_CYC);
    wire start_chk = nss_fall & pend_chk_reg & gap_in_window;
    wire gap_expired = ~selected & (gap_reg > scat_pkg::WIN_MAX_CYC);

    // MISO word: identity first, then register data, or the checksum
    wire [15:0] crc_value;
    wire [15:0] out_word = chk_txn_reg ? crc_value : (first_word ? ident_word_reg : data_word_reg);

    // Write side effects on User IO
    wire sensor_blk = (addr_reg[11:8] != 4'h0);
    wire wr_now = reg_word_done & ~first_word & write_reg;
    wire clr_hit = wr_now & sensor_blk & (addr_reg[7:0] == scat_pkg::CTRL_WORD_OFS) &
                   ~rx_next[scat_pkg::SAMPLE_FLAG_BIT];
    wire io_hit = wr_now & ((addr_reg == scat_pkg::IO_PIN_TYPE_ADDR) |
                            (sensor_blk & (addr_reg[7:0] == scat_pkg::IND_CTRL_OFS)));

    scat_crc16 u_crc (
        .clock(clock),
        .rst_n(rst_n),
        .clear(nss_fall & ~start_chk),
        .feed(reg_word_done),
        .word(out_word),
        .crc(crc_value)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sck_sync_reg <= 3'h0;
            nss_sync_reg <= 3'h7;
            mosi_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], sck};
            nss_sync_reg <= {nss_sync_reg[1:0], nss_n};
            mosi_sync_reg <= {mosi_sync_reg[0], mosi};
        end
    end

    // Bit and word framing; partial words never complete
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bit_cnt_reg <= 4'h0;
            word_cnt_reg <= 5'h00;
            rx_reg <= 16'h0000;
            pos_reg <= 4'hf;
        end else if (nss_fall) begin
            bit_cnt_reg <= 4'h0;
            word_cnt_reg <= 5'h00;
            pos_reg <= 4'hf;
        end else if (selected) begin
            if (sck_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                rx_reg <= rx_next;
            end
            if (word_done && word_cnt_reg != 5'h1f) begin
                word_cnt_reg <= word_cnt_reg + 5'h01;
            end
            if (sck_fall) begin
                pos_reg <= ~bit_cnt_reg;
            end
        end
    end

    // Transaction kind and gap timing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chk_txn_reg <= 1'b0;
            pend_chk_reg <= 1'b0;
            gap_reg <= '1;
            ident_word_reg <= 16'h0000;
        end else begin
            if (nss_fall) begin
                chk_txn_reg <= start_chk;
                pend_chk_reg <= 1'b0;
                ident_word_reg <= system_identity_word;
            end else if (nss_rise) begin
                pend_chk_reg <= ~chk_txn_reg;
            end else if (gap_expired) begin
                pend_chk_reg <= 1'b0;
            end
            if (nss_rise) begin
                gap_reg <= '0;
            end else if (~selected && gap_reg != '1) begin
                gap_reg <= gap_reg + 1'b1;
            end
        end
    end

    // Register requests; read data is taken the cycle after rd
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_reg <= '0;
            addr_reg <= 12'h000;
            write_reg <= 1'b0;
            rd_dly_reg <= 1'b0;
            data_word_reg <= 16'h0000;
        end else begin
            req_reg.wr <= 1'b0;
            req_reg.rd <= 1'b0;
            rd_dly_reg <= req_reg.rd;
            if (rd_dly_reg) begin
                data_word_reg <= reg_rdata;
            end
            if (reg_word_done) begin
                req_reg.rd <= 1'b1;
                if (first_word) begin
                    write_reg <= (rx_next[15:12] == scat_pkg::ACS_WRITE_READ);
                    addr_reg <= rx_next[11:0];
                    req_reg.addr <= rx_next[11:0];
                end else begin
                    req_reg.wr <= write_reg;
                    req_reg.wdata <= rx_next;
                    addr_reg <= addr_inc;
                    req_reg.addr <= write_reg ? addr_reg : addr_inc;
                end
            end else if (req_reg.wr) begin
                // Prefetch of the next word follows its write
                req_reg.rd <= 1'b1;
                req_reg.addr <= addr_reg;
            end
        end
    end

    // User IO side effects, issued once select returns high; IO apply also waits for running to drop
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clr_seen_reg <= 1'b0;
            io_seen_reg <= 1'b0;
            io_wait_reg <= 1'b0;
            clr_pulse_reg <= 1'b0;
            io_pulse_reg <= 1'b0;
            running_reg <= 1'b0;
        end else begin
            running_reg <= running_next;
            clr_pulse_reg <= nss_rise & clr_seen_reg;
            io_pulse_reg <= io_wait_reg & ~running_reg & ~io_pulse_reg;
            if (nss_fall) begin
                clr_seen_reg <= 1'b0;
                io_seen_reg <= 1'b0;
            end else begin
                if (clr_hit) begin
                    clr_seen_reg <= 1'b1;
                end
                if (io_hit) begin
                    io_seen_reg <= 1'b1;
                end
            end
            if (nss_rise && io_seen_reg) begin
                io_wait_reg <= 1'b1;
            end else if (io_pulse_reg) begin
                io_wait_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            miso_reg <= 1'b0;
            miso_oe_n_reg <= 1'b1;
        end else begin
            miso_reg <= out_word[pos_reg];
            miso_oe_n_reg <= ~selected;
        end
    end

    assign reg_req = req_reg;
    assign miso_pin.miso = miso_reg;
    assign miso_pin.miso_oe_n = miso_oe_n_reg;
    assign indicator_clear_pulse = clr_pulse_reg;
    assign io_apply_pulse = io_pulse_reg;
    assign measure_running = running_reg;
    assign checksum_active = chk_txn_reg;
endmodule // scat_spi_slave

/* File: bench/scat_spi_host.sv */
`timescale 1ns/1ps
module scat_spi_host (
    input wire logic clock,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic nss_n
);
    logic [15:0] tx_q [$];
    logic [15:0] rx_q [$];
    logic [15:0] sh;
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        nss_n = 1'b1;
    end
    // Frames start off the system clock phase on purpose
    task automatic xfer(input int gap_ns, input int nbits);
        int i;
        #(gap_ns);
        @(posedge clock);
        #3 nss_n = 1'b0;
        rx_q.delete();
        #200;
        for (i = 0; i < nbits; i++) begin
            mosi = tx_q[i / 16][15 - i % 16];
            #140 sck = 1'b1;
            sh = {sh[14:0], miso};
            if (i % 16 == 15)
                rx_q.push_back(sh);
            #60 sck = 1'b0;
            // Long spacing is safe whether or not a measurement runs
            if (i == 15)
                #8000;
            else if (i % 16 == 15)
                #1200;
        end
        mosi = ~mosi;
        #100 nss_n = 1'b1;
    endtask
endmodule // scat_spi_host

/* File: bench/scat_spi_slave_monitor.sv */
`timescale 1ns/1ps
module scat_spi_slave_monitor #(
    parameter int N_SENSORS = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic nss_n,
    input wire logic [N_SENSORS-1:0] sensor_go,
    input wire logic [N_SENSORS-1:0] continuous_measure_bit,
    input wire logic [N_SENSORS-1:0] sample_indicator_flag,
    input wire scat_pkg::scat_reg_req_t reg_req,
    input wire scat_pkg::scat_miso_pin_t miso_pin,
    input wire logic indicator_clear_pulse,
    input wire logic io_apply_pulse,
    input wire logic measure_running,
    input wire logic checksum_active
);
    logic [10:0] gap_reg;
    logic nd_reg;
    logic cd_reg;
    logic id_reg;
    logic [10:0] cc_reg;
    logic [10:0] ic_reg;
    wire logic busy = |(continuous_measure_bit & sensor_go) | |(sensor_go & ~sample_indicator_flag);
    wire logic blk = reg_req.wr && reg_req.addr[11:8] != 4'h0;
    wire logic clr_wr = blk && reg_req.addr[7:0] == scat_pkg::CTRL_WORD_OFS
        && !reg_req.wdata[scat_pkg::SAMPLE_FLAG_BIT];
    wire logic io_wr = (blk && reg_req.addr[7:0] == scat_pkg::IND_CTRL_OFS)
        || (reg_req.wr && reg_req.addr == scat_pkg::IO_PIN_TYPE_ADDR);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            {gap_reg, cd_reg, id_reg, cc_reg, ic_reg} <= '0;
            nd_reg <= 1'b1;
        end else begin
            nd_reg <= nss_n;
            gap_reg <= (nss_n && !nd_reg) ? 11'h001 : gap_reg + 11'((nss_n && gap_reg != 11'h7ff) ? 1 : 0);
            cd_reg <= clr_wr | (cd_reg & ~indicator_clear_pulse);
            id_reg <= io_wr | (id_reg & ~io_apply_pulse);
            cc_reg <= (cd_reg && nss_n) ? cc_reg + 11'h001 : 11'h000;
            // Time spent running does not count against the deadline
            ic_reg <= !id_reg ? 11'h000 : ic_reg + 11'((nss_n && !measure_running) ? 1 : 0);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_running_follows: assert property ($past(rst_n) |-> measure_running == $past(busy))
        else $error("running flag wrong");
    a_clear_deadline: assert property (cc_reg <= 11'h3e8)
        else $error("indicator clear late");
    a_io_deadline: assert property (ic_reg <= 11'h4b0)
        else $error("io apply late");
    a_clear_after_select: assert property (indicator_clear_pulse |-> nss_n && $past(nss_n, 2))
        else $error("clear pulse inside frame");
    a_miso_driven: assert property (!nss_n [*4] |=> !miso_pin.miso_oe_n)
        else $error("miso not driven");
    a_checksum_gap_ok: assert property ($rose(checksum_active) |-> gap_reg >= 11'h076 && gap_reg <= 11'h2fa)
        else $error("checksum outside window");
    a_long_gap_drop: assert property ($fell(nss_n) && gap_reg > 11'h30c |-> ##8 !checksum_active)
        else $error("checksum after long gap");
    a_window_hit: assert property ($fell(nss_n) && !checksum_active && gap_reg <= 11'h2ee
        && gap_reg >= (measure_running ? 11'h14a : 11'h082) |-> ##8 checksum_active)
        else $error("checksum read missed");
endmodule // scat_spi_slave_monitor

bind scat_spi_slave scat_spi_slave_monitor #(.N_SENSORS(N_SENSORS)) i_scat_spi_slave_monitor (
    .clock(clock), .rst_n(rst_n), .nss_n(nss_n), .sensor_go(sensor_go),
    .continuous_measure_bit(continuous_measure_bit), .sample_indicator_flag(sample_indicator_flag),
    .reg_req(reg_req), .miso_pin(miso_pin), .indicator_clear_pulse(indicator_clear_pulse),
    .io_apply_pulse(io_apply_pulse), .measure_running(measure_running), .checksum_active(checksum_active));

/* File: bench/scat_spi_slave_tb_top.sv */
`timescale 1ns/1ps
module scat_spi_slave_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sck;
    logic mosi;
    logic nss_n;
    logic [15:0] ident = 16'h0000;
    logic [1:0] go = 2'h0;
    logic [1:0] cmode = 2'h0;
    logic [1:0] flags = 2'h0;
    logic [15:0] rdata;
    scat_pkg::scat_reg_req_t req;
    scat_pkg::scat_miso_pin_t mp;
    logic clr_p;
    logic io_p;
    logic cks;
    logic [15:0] mem [0:4095];
    logic [15:0] ref_m [0:4095];
    logic [15:0] exp_q [$];
    int n_errors = 0;
    int checks_done = 0;
    int i;
    int n;
    always #12.5 clock = ~clock;
    // Combinational so either reading of the read-data slot holds
    always_comb rdata = mem[req.addr];
    always @(posedge clock)
        if (req.wr)
            mem[req.addr] <= req.wdata;
    scat_spi_slave #(.N_SENSORS(2)) i_scat_spi_slave (
        .clock(clock), .rst_n(rst_n), .sck(sck), .mosi(mosi), .nss_n(nss_n),
        .system_identity_word(ident), .sensor_go(go), .continuous_measure_bit(cmode),
        .sample_indicator_flag(flags), .reg_rdata(rdata), .reg_req(req), .miso_pin(mp),
        .indicator_clear_pulse(clr_p), .io_apply_pulse(io_p), .measure_running(), .checksum_active(cks));
    // No pull on the line: a released MISO shows the inverse so early sampling shows up
    scat_spi_host i_scat_spi_host (.clock(clock), .miso(mp.miso_oe_n ? ~mp.miso : mp.miso), .sck(sck),
        .mosi(mosi), .nss_n(nss_n));
    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] crc_of();
        logic [15:0] c;
        c = 16'h0000;
        foreach (exp_q[w])
            for (int b = 15; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ exp_q[w][b]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction
    task automatic watch(input logic io, input int lim, input logic must);
        n = 0;
        while ((io ? io_p : clr_p) !== 1'b1 && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (must && (io ? io_p : clr_p) !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: pulse missing", $time);
            complete_run();
        end
    endtask
    task automatic reg_txn(input int gap, input logic wr, input logic [11:0] a, input int nw, input int extra);
        logic [15:0] w;
        int k;
        i_scat_spi_host.tx_q = {{wr ? 4'hf : 4'h0, a}};
        exp_q = {ident};
        for (k = 0; k <= nw; k++) begin
            w = 16'($urandom) & 16'h7fff;
            i_scat_spi_host.tx_q.push_back(w);
            if (k < nw) begin
                exp_q.push_back(ref_m[a + k]);
                if (wr)
                    ref_m[a + k] = w;
            end
        end
        i_scat_spi_host.xfer(gap, 16 * (nw + 1) + extra);
        for (k = 0; k <= nw; k++)
            chk(i_scat_spi_host.rx_q[k], exp_q[k]);
        chk_flag(cks, 1'b0);
    endtask
    task automatic cks_txn;
        i_scat_spi_host.tx_q = {16'h0000};
        i_scat_spi_host.xfer(10000, 16);
        chk(i_scat_spi_host.rx_q[0], crc_of());
        chk_flag(cks, 1'b1);
    endtask
    initial begin
        void'($urandom(46));
        for (i = 0; i < 4096; i++) begin
            mem[i] = 16'($urandom);
            ref_m[i] = mem[i];
        end
        ident <= 16'($urandom);
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        reg_txn(30000, 1'b0, 12'h105, 15, 0);
        cks_txn();
        reg_txn(30000, 1'b1, 12'h100, 2, 5);
        watch(1'b0, 1000, 1'b1);
        cks_txn();
        reg_txn(30000, 1'b0, 12'h100, 3, 0);
        reg_txn(30000, 1'b1, scat_pkg::IO_PIN_TYPE_ADDR, 1, 0);
        watch(1'b1, 1200, 1'b1);
        go <= 2'b01;
        reg_txn(30000, 1'b1, 12'h112, 1, 0);
        cks_txn();
        watch(1'b1, 1400, 1'b0);
        chk_flag(n == 1400 && io_p !== 1'b1, 1'b1);
        flags <= 2'b01;
        watch(1'b1, 100, 1'b1);
        cmode <= 2'b10;
        go <= 2'b11;
        reg_txn(30000, 1'b0, 12'h200, 2, 0);
        reg_txn(5000, 1'b0, 12'h202, 1, 0);
        complete_run();
    end
endmodule // scat_spi_slave_tb_top
